/* File: dv/lmef_flags_tb.sv */
`timescale 1ns/1ps
module lmef_flags_tb;
  import lmef_pkg::*;
  logic              ref_clk_in, sys_rst_in, operating_in, reg_wr_in, reg_rd_in, irq_out;
  logic              rd_present_in, loopback_done_in, loopback_fail_in, lb_seen;
  logic [SW_W-1:0]   sw_pins_in, capt;
  logic [STN_W-1:0]  rd_station_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out, err_flags_out, rd_v;
  int                err_count, checks, cyc, m_flags, m_stat, m_mask;
  logic [6:0]        stns [6];

  lmef_flags u_lmef_flags (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .sw_pins_in(sw_pins_in), .operating_in(operating_in), .rd_present_in(rd_present_in),
    .rd_station_in(rd_station_in), .loopback_done_in(loopback_done_in),
    .loopback_fail_in(loopback_fail_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .err_flags_out(err_flags_out), .irq_out(irq_out));
  lmef_partner u_lmef_partner (.ref_clk_in(ref_clk_in), .rd_present_out(rd_present_in),
    .rd_station_out(rd_station_in), .lb_done_out(loopback_done_in),
    .lb_fail_out(loopback_fail_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic chk_irq(input logic exp);
    checks++;
    if (irq_out !== exp) begin
      err_count++;
      $display("wrong value irq exp %b got %b", exp, irq_out);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge ref_clk_in);
    d = reg_rdata_out;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    if (a == OFS_IRQ_STAT) m_stat &= ~int'(d);
    if (a == OFS_IRQ_MASK) m_mask = int'(d & FLAGS_IMPL);
  endtask

  task automatic do_reset(input logic [SW_W-1:0] sw);
    @(posedge ref_clk_in);
    sys_rst_in <= 1'b1;
    sw_pins_in <= sw;
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    capt    = sw;
    lb_seen = 1'b0;
    m_flags = 0;
    m_stat  = 0;
    m_mask  = 0;
  endtask

  // Model of the flag word, stepped once the inputs have settled
  task automatic check();
    int nf;
    repeat (8) @(posedge ref_clk_in);
    nf = m_flags;
    if (!SPEED_OK_RST[capt[SPEED_W-1:0]]) nf |= 1 << BIT_SPEED;
    if (rd_present_in && (rd_station_in < RD_STN_MIN || rd_station_in > RD_STN_MAX ||
        capt[SW_FOUR_PT])) nf |= 1 << BIT_PLACE;
    if (sw_pins_in != capt && operating_in) nf |= 1 << BIT_SWCHG;
    if (sw_pins_in == capt) nf &= ~(1 << BIT_SWCHG);
    if (lb_seen) nf |= 1 << BIT_HWERR;
    m_stat |= nf & ~m_flags;
    m_flags = nf;
    chk("flags_out", m_flags[15:0], err_flags_out);
    rd(OFS_FLAGS, rd_v);
    chk("flags_reg", m_flags[15:0], rd_v);
    rd(OFS_IRQ_STAT, rd_v);
    chk("irq_stat", m_stat[15:0], rd_v);
    chk_irq(|(m_stat & m_mask));
    rd(OFS_IRQ_MASK, rd_v);
    chk("irq_mask", m_mask[15:0], rd_v);
    rd(OFS_SW_CAPT, rd_v);
    chk("sw_capt", 16'(capt), rd_v);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    {sys_rst_in, operating_in, reg_wr_in, reg_rd_in} = 4'h8;
    {sw_pins_in, reg_addr_in, reg_wdata_in} = '0;
    void'($urandom(32'h3B99));
    stns = '{7'h30, 7'h31, 7'h40, 7'h41, 7'h00, 7'h00};
    stns[4] = 7'($urandom_range(127, 0));
    stns[5] = 7'($urandom_range(127, 0));
    do_reset(5'h00);
    check();
    wr(OFS_FLAGS, 16'hFFFF);
    check();
    rd(8'h10, rd_v);
    chk("unmapped", 16'h0000, rd_v);
    foreach (stns[i]) begin
      u_lmef_partner.attach(stns[i]);
      check();
      u_lmef_partner.detach();
      check();
      do_reset(5'h00);
      check();
    end
    do_reset(5'h04);
    u_lmef_partner.attach(7'h32);
    check();
    u_lmef_partner.detach();
    do_reset(5'h03);
    check();
    wr(OFS_IRQ_MASK, 16'hFFFF);
    check();
    wr(OFS_IRQ_STAT, 16'h0010);
    sw_pins_in <= 5'h00;
    check();
    do_reset(5'h00);
    check();
    wr(OFS_IRQ_MASK, 16'h0100);
    operating_in <= 1'b1;
    sw_pins_in   <= capt ^ 5'(1 + $urandom_range(30, 0));
    check();
    sw_pins_in <= capt;
    check();
    u_lmef_partner.loop_test(1'b0, 40);
    check();
    u_lmef_partner.loop_test(1'b1, 3);
    lb_seen = 1'b1;
    check();
    repeat (50) @(posedge ref_clk_in);
    check();
    final_report();
  end
endmodule // lmef_flags_tb

/* File: dv/lmef_partner.sv */
`timescale 1ns/1ps
module lmef_partner (
  input  wire logic       ref_clk_in,
  output logic            rd_present_out,
  output logic      [6:0] rd_station_out,
  output logic            lb_done_out,
  output logic            lb_fail_out
);
  logic [6:0] stn_q;
  logic [6:0] tog_q;

  initial begin
    rd_present_out = 1'b0;
    stn_q          = 7'h00;
    tog_q          = 7'h00;
    lb_done_out    = 1'b0;
    lb_fail_out    = 1'b0;
  end

  // A released station line keeps moving, never a stale number
  always @(posedge ref_clk_in) begin
    tog_q <= tog_q + 7'h35;
  end
  assign rd_station_out = rd_present_out ? stn_q : tog_q;

  task automatic attach(input logic [6:0] stn);
    @(posedge ref_clk_in);
    stn_q          <= stn;
    rd_present_out <= 1'b1;
  endtask

  task automatic detach();
    @(posedge ref_clk_in);
    rd_present_out <= 1'b0;
  endtask

  // Loop-back test reports once after a variable time
  task automatic loop_test(input logic fail, input int dly);
    repeat (dly) @(posedge ref_clk_in);
    lb_done_out <= 1'b1;
    lb_fail_out <= fail;
    @(posedge ref_clk_in);
    lb_done_out <= 1'b0;
    lb_fail_out <= ~fail;
  endtask
endmodule // lmef_partner

/* File: hw/lmef_flags.sv */
`timescale 1ns/1ps
module lmef_flags
  import lmef_pkg::*;
#(
  parameter logic [3:0] SPEED_OK = lmef_pkg::SPEED_OK_RST
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        sys_rst_in,
  input  wire logic [lmef_pkg::SW_W-1:0]   sw_pins_in,
  input  wire logic                        operating_in,
  input  wire logic                        rd_present_in,
  input  wire logic [lmef_pkg::STN_W-1:0]  rd_station_in,
  input  wire logic                        loopback_done_in,
  input  wire logic                        loopback_fail_in,
  input  wire logic [lmef_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [lmef_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [lmef_pkg::DATA_W-1:0] reg_rdata_out,
  output logic      [lmef_pkg::DATA_W-1:0] err_flags_out,
  output logic                             irq_out
);
  import lmef_pkg::*;

  lmef_sw_if sw ();

  // One register per flag so that each has a single process driving it
  logic              speed_q;
  logic              place_q;
  logic              swchg_q;
  logic              hwerr_q;
  logic [DATA_W-1:0] flags_w;
  logic [DATA_W-1:0] flags_prev_q;
  logic [DATA_W-1:0] irq_stat_q;
  logic [DATA_W-1:0] irq_mask_q;
  logic [DATA_W-1:0] rdata_q;
  logic              speed_bad;
  logic              place_bad;
  logic              stn_out;

  function automatic logic stn_outside(input logic [STN_W-1:0] stn);
    return (stn < RD_STN_MIN) || (stn > RD_STN_MAX);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Switch capture
  lmef_sw_mon u_sw_mon (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .sw_pins_in (sw_pins_in),
    .sw         (sw.mon)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Condition detection
  // Speed and point mode come from the power-on image: a new setting only
  // takes effect after a reset.
  always_comb begin
    speed_bad = sw.capt_valid && !SPEED_OK[sw.capt[SPEED_W-1:0]];
    stn_out   = stn_outside(rd_station_in);
    place_bad = sw.capt_valid && rd_present_in
                && (stn_out || sw.capt[SW_FOUR_PT]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit 4: set by condition, held until reset
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      speed_q <= 1'b0;
    end else if (speed_bad) begin
      speed_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit 6: set by condition, held until reset
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      place_q <= 1'b0;
    end else if (place_bad) begin
      place_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit 8: switch changed during operation, clears on match
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      swchg_q <= 1'b0;
    end else if (sw.differ && operating_in) begin
      swchg_q <= 1'b1;
    end else if (!sw.differ) begin
      swchg_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit 15: hardware fault from loop-back test, no automatic clear
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      hwerr_q <= 1'b0;
    end else if (loopback_done_in && loopback_fail_in) begin
      hwerr_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word assembly: reserved and foreign bit positions are tied low
  always_comb begin
    flags_w            = FLAGS_RST;
    flags_w[BIT_SPEED] = speed_q;
    flags_w[BIT_PLACE] = place_q;
    flags_w[BIT_SWCHG] = swchg_q;
    flags_w[BIT_HWERR] = hwerr_q;
  end

  assign err_flags_out = flags_w & FLAGS_IMPL;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: rising flag edges, write one to clear, set wins
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      flags_prev_q <= FLAGS_RST;
    end else begin
      flags_prev_q <= flags_w & FLAGS_IMPL;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= ((reg_wr_in && hit(reg_addr_in, OFS_IRQ_STAT))
                     ? (irq_stat_q & ~reg_wdata_in) : irq_stat_q)
                    | (flags_w & FLAGS_IMPL & ~flags_prev_q);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_mask_q <= MASK_RST;
    end else if (reg_wr_in && hit(reg_addr_in, OFS_IRQ_MASK)) begin
      irq_mask_q <= reg_wdata_in & FLAGS_IMPL;
    end
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Register read port; the flag word has no write path
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        OFS_FLAGS:    rdata_q <= flags_w & FLAGS_IMPL;
        OFS_IRQ_STAT: rdata_q <= irq_stat_q;
        OFS_IRQ_MASK: rdata_q <= irq_mask_q;
        OFS_SW_CAPT:  rdata_q <= {{(DATA_W-SW_W){1'b0}}, sw.capt};
        default:      rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  reserved_zero_a: assert property ((err_flags_out & ~FLAGS_IMPL) == 16'h0000)
    else $error("reserved flag bit set");

  speed_sets_a: assert property (speed_bad |=> err_flags_out[BIT_SPEED])
    else $error("speed flag not set");

  speed_holds_a: assert property (err_flags_out[BIT_SPEED] |=> err_flags_out[BIT_SPEED])
    else $error("speed flag dropped without reset");

  place_range_a: assert property (
    sw.capt_valid && rd_present_in && stn_outside(rd_station_in)
    |=> err_flags_out[BIT_PLACE])
    else $error("placement flag not set for station range");

  place_fourpt_a: assert property (
    sw.capt_valid && rd_present_in && sw.capt[SW_FOUR_PT]
    |=> err_flags_out[BIT_PLACE])
    else $error("placement flag not set in four-point mode");

  place_holds_a: assert property (err_flags_out[BIT_PLACE] |=> err_flags_out[BIT_PLACE])
    else $error("placement flag dropped without reset");

  swchg_sets_a: assert property (sw.differ && operating_in |=> err_flags_out[BIT_SWCHG])
    else $error("switch change flag not set");

  swchg_clears_a: assert property (!sw.differ |=> !err_flags_out[BIT_SWCHG])
    else $error("switch change flag not cleared on match");

  hwerr_sets_a: assert property (
    loopback_done_in && loopback_fail_in |=> err_flags_out[BIT_HWERR])
    else $error("hardware flag not set");

  hwerr_sticky_a: assert property (
    err_flags_out[BIT_HWERR] |=> err_flags_out[BIT_HWERR] [*8])
    else $error("hardware flag cleared");

  write_ignored_a: assert property (
    reg_wr_in && hit(reg_addr_in, OFS_FLAGS) && !speed_bad && !place_bad
    && !sw.differ && !loopback_done_in
    |=> $stable(err_flags_out))
    else $error("write changed status word");

  read_flags_a: assert property (
    reg_rd_in && hit(reg_addr_in, OFS_FLAGS)
    |=> reg_rdata_out == $past(flags_w & FLAGS_IMPL))
    else $error("flag read data wrong");

  rst_clears_a: assert property (disable iff (1'b0)
    sys_rst_in |=> (err_flags_out == 16'h0000) && !irq_out)
    else $error("outputs not cleared by reset");

  speed_quiet_a: assert property (
    !speed_bad && !err_flags_out[BIT_SPEED] |=> !err_flags_out[BIT_SPEED])
    else $error("speed flag set without cause");

  place_quiet_a: assert property (
    !place_bad && !err_flags_out[BIT_PLACE] |=> !err_flags_out[BIT_PLACE])
    else $error("placement flag set without cause");

  swchg_quiet_a: assert property (
    !(sw.differ && operating_in) && !err_flags_out[BIT_SWCHG]
    |=> !err_flags_out[BIT_SWCHG])
    else $error("switch change flag set without cause");

  swchg_keep_a: assert property (
    sw.differ && !operating_in |=> $stable(err_flags_out[BIT_SWCHG]))
    else $error("switch change flag moved while idle");

  hwerr_quiet_a: assert property (
    !(loopback_done_in && loopback_fail_in) && !err_flags_out[BIT_HWERR]
    |=> !err_flags_out[BIT_HWERR])
    else $error("hardware flag set without cause");

  ////////////////////////////////////////////////////////////////////////////
  // Register and interrupt checks
  // A new flag edge must survive a clear written in the same cycle
  irq_set_wins_a: assert property (
    reg_wr_in && hit(reg_addr_in, OFS_IRQ_STAT)
    |=> (irq_stat_q & $past(flags_w & ~flags_prev_q)) == $past(flags_w & ~flags_prev_q))
    else $error("interrupt set lost to clear");

  irq_w1c_a: assert property (
    reg_wr_in && hit(reg_addr_in, OFS_IRQ_STAT)
    |=> (irq_stat_q & $past(reg_wdata_in & ~(flags_w & ~flags_prev_q))) == 16'h0000)
    else $error("interrupt status not cleared by write");

  mask_write_a: assert property (
    reg_wr_in && hit(reg_addr_in, OFS_IRQ_MASK)
    |=> irq_mask_q == $past(reg_wdata_in & FLAGS_IMPL))
    else $error("interrupt mask write wrong");

  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("read data not zero when idle");

  rd_capt_a: assert property (
    reg_rd_in && hit(reg_addr_in, OFS_SW_CAPT)
    |=> reg_rdata_out == 16'($past(sw.capt)))
    else $error("captured switch read wrong");

  unmapped_zero_a: assert property (
    reg_rd_in && !hit(reg_addr_in, OFS_FLAGS) && !hit(reg_addr_in, OFS_IRQ_STAT)
    && !hit(reg_addr_in, OFS_IRQ_MASK) && !hit(reg_addr_in, OFS_SW_CAPT)
    |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");

  irq_level_a: assert property (
    $rose(err_flags_out[BIT_HWERR]) && irq_mask_q[BIT_HWERR] |=> irq_out)
    else $error("interrupt missing for hardware fault");

  cov_speed_c:  cover property (speed_bad ##1 err_flags_out[BIT_SPEED]);
  cov_place_c:  cover property (rd_present_in && sw.capt_valid && stn_out);
  cov_swchg_c:  cover property ($rose(err_flags_out[BIT_SWCHG]) ##[1:50]
                                $fell(err_flags_out[BIT_SWCHG]));
  cov_hwerr_c:  cover property (loopback_done_in && loopback_fail_in ##2 irq_out);

endmodule : lmef_flags

/* File: hw/lmef_pkg.sv */
package lmef_pkg;

  // Register bus
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 16;
  localparam logic [7:0]  OFS_FLAGS    = 8'h00;
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0]  OFS_SW_CAPT  = 8'h0C;

  // Detailed error word layout
  localparam int          BIT_SPEED    = 4;
  localparam int          BIT_PLACE    = 6;
  localparam int          BIT_SWCHG    = 8;
  localparam int          BIT_HWERR    = 15;
  localparam logic [15:0] FLAGS_IMPL   = 16'h8150;
  localparam logic [15:0] FLAGS_RST    = 16'h0000;
  localparam logic [15:0] MASK_RST     = 16'h0000;

  // Selector switch bundle: {op_mode[1:0], four_point, speed[1:0]}
  localparam int          SPEED_W      = 2;
  localparam int          OPMODE_W     = 2;
  localparam int          SW_W         = SPEED_W + 1 + OPMODE_W;
  localparam int          SW_FOUR_PT   = SPEED_W;
  localparam logic [3:0]  SPEED_OK_RST = 4'h7;

  // Remote-device station window
  localparam int          STN_W        = 7;
  localparam logic [6:0]  RD_STN_MIN   = 7'h31;
  localparam logic [6:0]  RD_STN_MAX   = 7'h40;

  // Cycles after reset release before the captured switch image is trusted
  localparam logic [1:0]  CAPT_DELAY   = 2'h3;

endpackage : lmef_pkg

/* File: hw/lmef_sw_if.sv */
`timescale 1ns/1ps
interface lmef_sw_if;
  import lmef_pkg::*;
  logic [SW_W-1:0] live;
  logic [SW_W-1:0] capt;
  logic            capt_valid;
  logic            differ;

  modport mon  (output live, output capt, output capt_valid, output differ);
  modport core (input live, input capt, input capt_valid, input differ);
endinterface : lmef_sw_if

/* File: hw/lmef_sw_mon.sv */
`timescale 1ns/1ps
module lmef_sw_mon
  import lmef_pkg::*;
(
  input  wire logic                      ref_clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic [lmef_pkg::SW_W-1:0] sw_pins_in,
  lmef_sw_if.mon                         sw
);
  import lmef_pkg::*;

  logic [SW_W-1:0] meta_q;
  logic [SW_W-1:0] sync_q;
  logic [SW_W-1:0] capt_q;
  logic [1:0]      wait_q;
  logic            valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser for the switch pins
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= sw_pins_in;
      sync_q <= meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on capture once the synchroniser has filled
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wait_q  <= 2'h0;
      valid_q <= 1'b0;
      capt_q  <= '0;
    end else if (!valid_q) begin
      if (wait_q == CAPT_DELAY - 2'h1) begin
        valid_q <= 1'b1;
        capt_q  <= sync_q;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end

  assign sw.live       = sync_q;
  assign sw.capt       = capt_q;
  assign sw.capt_valid = valid_q;
  assign sw.differ     = valid_q && (sync_q != capt_q);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  capture_frozen_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $past(valid_q) && valid_q |-> $stable(capt_q))
    else $error("captured switch image changed after capture");

endmodule : lmef_sw_mon
